/* include/tps_defines.svh */
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TPS_OFS_MODE     8'h00
`define TPS_OFS_CTRL     8'h04
`define TPS_OFS_STATUS   8'h08
`define TPS_OFS_TXLOAD   8'h0C
`define TPS_OFS_RXDATA   8'h10
// ----------------------------------------
// mode register fields
// ----------------------------------------
`define TPS_MODE_TX_EN   0
`define TPS_MODE_RX_EN   1
`define TPS_MODE_REPEAT  2
`define TPS_MODE_HALT    3
`define TPS_MODE_SEL_LO  4
`define TPS_MODE_SEL_HI  5
`define TPS_MODE_USER    6
`define TPS_MODE_W       7
// ----------------------------------------
// control register fields (write-only pulses)
// ----------------------------------------
`define TPS_CTRL_GO      0
`define TPS_CTRL_STOP    1
`define TPS_CTRL_RXGO    2
`define TPS_CTRL_CLRERR  3
`define TPS_CTRL_FLUSH   4
// ----------------------------------------
// status register fields
// ----------------------------------------
`define TPS_ST_DONE      0
`define TPS_ST_ERR       1
`define TPS_ST_TXACT     2
`define TPS_ST_RXACT     3
`define TPS_ST_RXAVAIL   4
`define TPS_ST_LOAD_LO   8
`define TPS_ST_LOAD_HI   12
// ----------------------------------------
// pattern word layout and sizes
// ----------------------------------------
`define TPS_WORD_W       27
`define TPS_END_BIT      26
`define TPS_NOOP_BIT     25
`define TPS_PAT_DEPTH    16
`define TPS_PTR_W        4
`define TPS_RX_DEPTH     8
`define TPS_CTRL_LINES   3
// ----------------------------------------
// timing
// ----------------------------------------
`define TPS_CLK_MHZ      250
`define TPS_LED_LAG_MS   100
`define TPS_LED_CYCLES   (`TPS_LED_LAG_MS * `TPS_CLK_MHZ * 1000)
`endif

/* include/tps_pkg.sv */
`default_nettype none
package tps_pkg;
    // one pattern word: end marker, no-op marker, payload
    typedef logic [26:0] pattern_word_t;
    // sequencer states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } seq_state_t;
endpackage
`default_nettype wire

/* logic/pattern_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module pattern_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage
        logic [AW-1:0]               wp;    // write slot
        logic [AW-1:0]               rp;    // read slot
        logic [AW:0]                 cnt;   // words held
    } fifo_state_t;
    fifo_state_t s_q, s_d;
    logic push, pop;
    // honest flags straight from the count
    assign in_ready  = (s_q.cnt != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_ready & out_valid;
    // next state: push and pop may share a cycle
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    // register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // count never passes depth
    a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

/* logic/led_stretch.sv */
`timescale 1ns/1ps
`default_nettype none
module led_stretch #(
    parameter int LAG_CYCLES = 25000000
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic active,
    output logic      led
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic        led;   // shown level
        logic [31:0] cnt;   // how long active has disagreed
    } led_state_t;
    led_state_t s_q, s_d;
    assign led = s_q.led;
    // the lamp follows only after the new level has held for the lag,
    // so bursts shorter than the lag never light the lamp
    always_comb begin
        s_d = s_q;
        if (active == s_q.led) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= 32'(LAG_CYCLES - 1)) begin
            s_d.led = active;
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
    end
    // register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // lamp changes only after a full lag
    a_led_lag: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.led != $past(s_q.led)) |-> $past(s_q.cnt) == 32'(LAG_CYCLES - 1))
        else $error("lamp moved before lag ended");
endmodule
`default_nettype wire

/* logic/test_pattern_sequencer.sv */
// Contract
// - send pattern words, store returned words
// - go bit sends one sequence
// - end marker stops current transmission
// - status shows sequence finished
// - transmit lamp lit while active, lagged
// - sequences without end marker run on
// - repeat mode restarts sequence until stopped
// - halt-on-error stops on error
// - without halt mode errors are ignored
// - free receive runs until stop or full
// - receive follows transmit when transmit enabled
// - user mode bit drives chosen control line
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tps_defines.svh"
module test_pattern_sequencer #(
    parameter int LED_LAG_CYCLES = `TPS_LED_CYCLES
) (
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [31:0]                 reg_rdata,
    output tps_pkg::pattern_word_t      tx_data,
    output logic                        tx_valid,
    input  wire logic                   err_in,
    input  wire tps_pkg::pattern_word_t rx_data,
    input  wire logic                   rx_valid,
    output logic [`TPS_CTRL_LINES-1:0]  port_ctrl,
    output logic                        tx_led
);
    import tps_pkg::*;
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        seq_state_t                                  st;      // sequencer
        logic [`TPS_PAT_DEPTH-1:0][`TPS_WORD_W-1:0]  pat;     // pattern store
        logic [`TPS_PTR_W-1:0]                       wp;      // next load slot
        logic [`TPS_PTR_W-1:0]                       rp;      // next word to send
        logic [`TPS_PTR_W-1:0]                       seq_at;  // start of this run
        logic [`TPS_PTR_W:0]                         left;    // words loaded, unsent
        logic [`TPS_MODE_W-1:0]                      mode;    // mode register
        logic                                        done;    // sequence finished
        logic                                        err;     // halted on error
        logic                                        rec;     // free recording on
        logic [`TPS_WORD_W-1:0]                      txd;     // word on the port
        logic                                        txv;     // word valid
        logic [`TPS_CTRL_LINES-1:0]                  ctl;     // control lines
        logic [31:0]                                 rdata;   // read answer
    } seq_q_t;
    seq_q_t s_q, s_d;
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // true when an access hits the given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction
    logic wr_mode, wr_ctrl, wr_load, rd_rx;
    logic go, stop, rxgo, clrerr, flush;
    assign wr_mode = reg_wr & hit(reg_addr, `TPS_OFS_MODE);
    assign wr_ctrl = reg_wr & hit(reg_addr, `TPS_OFS_CTRL);
    assign wr_load = reg_wr & hit(reg_addr, `TPS_OFS_TXLOAD);
    assign rd_rx   = reg_rd & hit(reg_addr, `TPS_OFS_RXDATA);
    assign go      = wr_ctrl & reg_wdata[`TPS_CTRL_GO];
    assign stop    = wr_ctrl & reg_wdata[`TPS_CTRL_STOP];
    assign rxgo    = wr_ctrl & reg_wdata[`TPS_CTRL_RXGO];
    assign clrerr  = wr_ctrl & reg_wdata[`TPS_CTRL_CLRERR];
    assign flush   = wr_ctrl & reg_wdata[`TPS_CTRL_FLUSH];
    // ----------------------------------------
    // receive path
    // ----------------------------------------
    logic                   rx_ready, rx_avail, rx_push, recording, halt_now;
    logic [`TPS_WORD_W-1:0] rx_head;
    // with transmit enabled, recording is framed by the words on the port,
    // so the recorded length equals the sent length; the sending state
    // itself runs one cycle ahead of the port and would cut the last word;
    // otherwise it is a free run started by software
    assign recording = s_q.mode[`TPS_MODE_RX_EN] &
                       (s_q.mode[`TPS_MODE_TX_EN] ? s_q.txv : s_q.rec);
    assign rx_push   = recording & rx_valid;
    pattern_fifo #(
        .WIDTH (`TPS_WORD_W),
        .DEPTH (`TPS_RX_DEPTH)
    ) u_rx_fifo (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (rx_push),
        .in_ready  (rx_ready),
        .in_data   (rx_data),
        .out_valid (rx_avail),
        .out_ready (rd_rx),
        .out_data  (rx_head)
    );
    // error only counts when halt mode is set; otherwise ignored
    assign halt_now = err_in & s_q.mode[`TPS_MODE_HALT];
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [`TPS_WORD_W-1:0] word;
        word = s_q.pat[s_q.rp];
        s_d  = s_q;
        s_d.txv = 1'b0;
        // mode register
        if (wr_mode) begin
            s_d.mode = reg_wdata[`TPS_MODE_W-1:0];
        end
        // pattern loading; a flush in idle empties the store
        if (flush && s_q.st == ST_IDLE) begin
            s_d.wp     = '0;
            s_d.rp     = '0;
            s_d.seq_at = '0;
            s_d.left   = '0;
        end else if (wr_load) begin
            s_d.pat[s_q.wp] = reg_wdata[`TPS_WORD_W-1:0];
            s_d.wp          = s_q.wp + 1'b1;
            // store overflow overwrites the oldest slot; count saturates
            if (s_q.left != (`TPS_PTR_W+1)'(`TPS_PAT_DEPTH)) begin
                s_d.left = s_q.left + 1'b1;
            end
        end
        // error flag: a new error beats a clear in the same cycle
        if (clrerr) begin
            s_d.err = 1'b0;
        end
        // sequencer
        unique case (s_q.st)
            ST_IDLE: begin
                // stays put at the word after the last one sent
                if (go && s_q.left != '0 && s_q.mode[`TPS_MODE_TX_EN]) begin
                    s_d.st     = ST_SEND;
                    s_d.done   = 1'b0;
                    s_d.seq_at = s_q.rp;
                end
            end
            ST_SEND: begin
                if (stop) begin
                    s_d.st   = ST_IDLE;
                    s_d.done = 1'b1;
                end else if (halt_now) begin
                    // stop at once; word at rp is not sent
                    s_d.st   = ST_IDLE;
                    s_d.err  = 1'b1;
                    s_d.done = 1'b1;
                end else begin
                    s_d.txd = word;
                    s_d.txv = 1'b1;
                    s_d.rp  = s_q.rp + 1'b1;
                    if (!wr_load) begin
                        s_d.left = s_q.left - 1'b1;
                    end
                    if (s_q.mode[`TPS_MODE_REPEAT] &&
                        (word[`TPS_END_BIT] || s_q.left == (`TPS_PTR_W+1)'(1))) begin
                        // rewind; words re-enter the unsent count
                        s_d.rp   = s_q.seq_at;
                        s_d.left = s_q.left + (`TPS_PTR_W+1)'(s_q.rp - s_q.seq_at)
                                   + (`TPS_PTR_W+1)'(wr_load);
                    end else if (word[`TPS_END_BIT] || s_q.left == (`TPS_PTR_W+1)'(1)) begin
                        // end marker or store exhausted ends the run;
                        // no-op words carry no end marker so runs flow on
                        s_d.st   = ST_IDLE;
                        s_d.done = 1'b1;
                    end
                end
            end
        endcase
        // free recording: started by software, ended by stop or full
        if (rxgo) begin
            s_d.rec = 1'b1;
        end
        if (stop || (s_q.rec && !rx_ready)) begin
            s_d.rec = 1'b0;
        end
        // one chosen control line carries the user mode bit
        for (int i = 0; i < `TPS_CTRL_LINES; i++) begin
            s_d.ctl[i] = (s_q.mode[`TPS_MODE_SEL_HI:`TPS_MODE_SEL_LO] == 2'(i)) &
                         s_q.mode[`TPS_MODE_USER];
        end
        // read answer, valid the cycle after the strobe
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (hit(reg_addr, `TPS_OFS_MODE)) begin
                s_d.rdata[`TPS_MODE_W-1:0] = s_q.mode;
            end else if (hit(reg_addr, `TPS_OFS_STATUS)) begin
                s_d.rdata[`TPS_ST_DONE]   = s_q.done;
                s_d.rdata[`TPS_ST_ERR]    = s_q.err;
                s_d.rdata[`TPS_ST_TXACT]  = (s_q.st == ST_SEND);
                s_d.rdata[`TPS_ST_RXACT]  = recording;
                s_d.rdata[`TPS_ST_RXAVAIL] = rx_avail;
                s_d.rdata[`TPS_ST_LOAD_HI:`TPS_ST_LOAD_LO] = s_q.left;
            end else if (rd_rx) begin
                s_d.rdata[`TPS_WORD_W-1:0] = rx_avail ? rx_head : '0;
            end
        end
    end
    // ----------------------------------------
    // register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = s_q.rdata;
    assign tx_data   = s_q.txd;
    assign tx_valid  = s_q.txv;
    assign port_ctrl = s_q.ctl;
    led_stretch #(
        .LAG_CYCLES (LED_LAG_CYCLES)
    ) u_led (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .active  (s_q.st == ST_SEND),
        .led     (tx_led)
    );
    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_send_end;
        s_q.st == ST_SEND && !stop && !halt_now && !s_q.mode[`TPS_MODE_REPEAT]
        && s_q.pat[s_q.rp][`TPS_END_BIT];
    endsequence
    a_end_marker_stop: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_send_end |=> s_q.st == ST_IDLE && s_q.done && tx_valid) else $error("end marker missed");
    a_go_starts: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.st == ST_IDLE && go && s_q.left != '0 && s_q.mode[`TPS_MODE_TX_EN])
        |=> s_q.st == ST_SEND && !s_q.done) else $error("go did not start");
    a_halt_error: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.st == ST_SEND && !stop && err_in && s_q.mode[`TPS_MODE_HALT])
        |=> s_q.st == ST_IDLE && s_q.err && !tx_valid) else $error("error did not halt");
    a_err_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.st == ST_SEND && !stop && !s_q.mode[`TPS_MODE_HALT])
        |=> tx_valid) else $error("send stalled without halt mode");
    a_repeat_rewind: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.st == ST_SEND && !stop && !halt_now && s_q.mode[`TPS_MODE_REPEAT]
        && s_q.pat[s_q.rp][`TPS_END_BIT]) |=> s_q.st == ST_SEND && s_q.rp == $past(s_q.seq_at))
        else $error("repeat did not rewind");
    a_idle_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.st == ST_IDLE && !go && !flush) |=> $stable(s_q.rp) && !tx_valid)
        else $error("idle moved read point");
    a_rx_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.mode[`TPS_MODE_TX_EN] && !s_q.txv) |-> !rx_push)
        else $error("recorded outside send window");
    a_free_full: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.rec && !rx_ready && !rxgo) |=> !s_q.rec) else $error("free run passed full");
    a_ctrl_line: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ##1 port_ctrl == ($past(s_q.mode[`TPS_MODE_USER]) ?
        3'(1 << $past(s_q.mode[`TPS_MODE_SEL_HI:`TPS_MODE_SEL_LO])) : 3'h0))
        else $error("control line mismatch");
    a_status_done: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_rd && hit(reg_addr, `TPS_OFS_STATUS)) |=> reg_rdata[`TPS_ST_DONE] == $past(s_q.done))
        else $error("status done wrong");
endmodule
`default_nettype wire

/* tb/daughter_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side card: echoes sent words or plays a burst
// ----------------------------------------
module daughter_card_model #(
    parameter int BURST_N = 10
) (
    input  wire logic                   ref_clk,
    input  wire tps_pkg::pattern_word_t tx_data,
    input  wire logic                   tx_valid,
    input  wire logic                   echo_en,
    input  wire logic                   fake_err,
    input  wire logic                   burst_go,
    output logic                        err_in,
    output tps_pkg::pattern_word_t      rx_data,
    output logic                        rx_valid
);
    import tps_pkg::*;
    int            left_n;   // burst words still owed
    pattern_word_t burst_w;  // next burst word
    pattern_word_t idle_w;   // filler, flips each cycle so stale data never looks valid
    initial begin
        left_n = 0;
        burst_w = 27'h0000100;
        idle_w = 27'h5A5A5A5;
    end
    // a faked error looks exactly like a real one to the sequencer
    assign err_in = fake_err;
    // echo is prompt: returned frame lines up with the sent frame
    assign rx_valid = echo_en ? tx_valid : (left_n > 0);
    assign rx_data = (echo_en && tx_valid) ? tx_data : (!echo_en && left_n > 0) ? burst_w : idle_w;
    // burst counter and filler scrambler
    always @(posedge ref_clk) begin
        idle_w <= ~idle_w;
        if (burst_go) begin
            left_n <= BURST_N;
        end else if (left_n > 0) begin
            left_n <= left_n - 1;
            burst_w <= burst_w + 27'h0000001;
        end
    end
endmodule
`default_nettype wire

/* tb/test_pattern_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tps_defines.svh"
module test_pattern_sequencer_bench;
    import tps_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    typedef struct {logic [7:0] a; logic [31:0] d; bit wr; logic [31:0] x;} row_t;
    logic          ref_clk, reset_n, reg_wr, reg_rd, tx_valid, err_in, rx_valid, tx_led;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata, q;
    logic [2:0]    port_ctrl;
    logic          echo_en, fake_err, burst_go;
    pattern_word_t tx_data, rx_data;
    pattern_word_t txq[$];   // every word seen leaving the sequencer
    int            fails, num_checks, i;
    row_t          rows[11];
    // ----------------------------------------
    // design and far-side card
    // ----------------------------------------
    test_pattern_sequencer #(.LED_LAG_CYCLES(8)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_valid(tx_valid), .err_in(err_in),
        .rx_data(rx_data), .rx_valid(rx_valid), .port_ctrl(port_ctrl), .tx_led(tx_led));
    daughter_card_model card_u (.ref_clk(ref_clk), .tx_data(tx_data), .tx_valid(tx_valid),
        .echo_en(echo_en), .fake_err(fake_err), .burst_go(burst_go), .err_in(err_in),
        .rx_data(rx_data), .rx_valid(rx_valid));
    // ----------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // tx_valid stands one cycle per word, so sample every edge
    always @(posedge ref_clk) if (tx_valid === 1'b1) txq.push_back(tx_data);
    // whole run is a few hundred cycles; this is ample
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        wrap_up;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe edge
    task rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        r = reg_rdata;
    endtask
    // bounded poll of the done flag
    task wait_done;
        int n;
        n = 0;
        q = 32'h0;
        while (q[`TPS_ST_DONE] !== 1'b1 && n < 40) begin
            rd(`TPS_OFS_STATUS, q);
            n++;
        end
        if (n >= 40) fails++;
    endtask
    task chk_q(input logic [31:0] e[$]);
        chk(32'(txq.size()), 32'(e.size()));
        foreach (e[k]) if (k < txq.size()) chk(32'(txq[k]), e[k]);
        txq.delete();
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        {reg_wr, reg_rd, echo_en, fake_err, burst_go} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        fails = 0;
        num_checks = 0;
        // status clean, readback, unmapped place, load count, flush, empty rx
        rows = '{'{8'h08, 0, 0, 32'h0}, '{8'h00, 32'h4B, 1, 0}, '{8'h00, 0, 0, 32'h4B},
                 '{8'h40, 32'hFFFF, 1, 0}, '{8'h40, 0, 0, 32'h0}, '{8'h0C, 32'h11, 1, 0},
                 '{8'h0C, 32'h22, 1, 0}, '{8'h08, 0, 0, 32'h200}, '{8'h04, 32'h10, 1, 0},
                 '{8'h08, 0, 0, 32'h0}, '{8'h10, 0, 0, 32'h0}};
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (rows[r]) begin
            if (rows[r].wr) wr(rows[r].a, rows[r].d);
            else begin
                rd(rows[r].a, q);
                chk(q, rows[r].x);
            end
        end
        // user bit steered onto each control line in turn
        for (i = 0; i < 3; i++) begin
            wr(8'h00, 32'h40 | (i << 4));
            repeat (2) @(posedge ref_clk);
            chk(32'(port_ctrl), 32'h1 << i);
        end
        // single step: no-op word runs on, end marker stops, next go resumes
        wr(8'h00, 32'h01);
        wr(8'h0C, 32'h11);
        wr(8'h0C, 32'h2000022);
        wr(8'h0C, 32'h4000033);
        wr(8'h0C, 32'h4000044);
        txq.delete();
        wr(8'h04, 32'h01);
        wait_done;
        chk_q('{32'h11, 32'h2000022, 32'h4000033});
        rd(8'h08, q);
        chk(q, 32'h101);
        wr(8'h04, 32'h01);
        wait_done;
        chk_q('{32'h4000044});
        // repeat mode keeps cycling; lamp lags activity both ways
        wr(8'h00, 32'h05);
        wr(8'h0C, 32'h55);
        wr(8'h0C, 32'h4000066);
        wr(8'h04, 32'h01);
        repeat (24) @(posedge ref_clk);
        chk(32'(tx_led), 32'h1);
        wr(8'h04, 32'h02);
        wait_done;
        for (i = 0; i < 4; i++) chk(32'(txq[i]), i[0] ? 32'h4000066 : 32'h55);
        repeat (12) @(posedge ref_clk);
        chk(32'(tx_led), 32'h0);
        wr(8'h04, 32'h10);
        txq.delete();
        // halt on error: card fakes an error after the first word
        wr(8'h00, 32'h09);
        for (i = 0; i < 6; i++) wr(8'h0C, 32'h100 + i);
        wr(8'h04, 32'h01);
        // raise the error as the first word is seen; the second is already
        // launched, the third is held back by the halt
        @(posedge ref_clk iff tx_valid === 1'b1);
        fake_err <= 1'b1;
        wait_done;
        chk(32'(txq.size()), 32'h2);
        rd(8'h08, q);
        chk(q, 32'h403);
        @(posedge ref_clk);
        fake_err <= 1'b0;
        wr(8'h04, 32'h08);
        txq.delete();
        // without halt mode a standing error changes nothing
        wr(8'h00, 32'h01);
        @(posedge ref_clk);
        fake_err <= 1'b1;
        wr(8'h04, 32'h01);
        wait_done;
        chk_q('{32'h102, 32'h103, 32'h104, 32'h105});
        rd(8'h08, q);
        chk(q, 32'h001);
        @(posedge ref_clk);
        fake_err <= 1'b0;
        // receive slaved to transmit: recorded length equals sent length
        @(posedge ref_clk);
        echo_en <= 1'b1;
        wr(8'h00, 32'h03);
        wr(8'h0C, 32'h31);
        wr(8'h0C, 32'h32);
        wr(8'h0C, 32'h4000033);
        wr(8'h04, 32'h01);
        wait_done;
        chk_q('{32'h31, 32'h32, 32'h4000033});
        for (i = 0; i < 4; i++) begin
            rd(8'h10, q);
            chk(q, i == 0 ? 32'h31 : i == 1 ? 32'h32 : i == 2 ? 32'h4000033 : 32'h0);
        end
        @(posedge ref_clk);
        echo_en <= 1'b0;
        // free recording: ten words offered, fifo of eight fills and stops
        wr(8'h00, 32'h02);
        wr(8'h04, 32'h04);
        @(posedge ref_clk);
        burst_go <= 1'b1;
        @(posedge ref_clk);
        burst_go <= 1'b0;
        repeat (14) @(posedge ref_clk);
        rd(8'h08, q);
        chk(q, 32'h11);
        for (i = 0; i < 9; i++) begin
            rd(8'h10, q);
            chk(q, i < 8 ? 32'h100 + i : 32'h0);
        end
        // reset in mid-run clears everything
        wr(8'h00, 32'h45);
        wr(8'h0C, 32'h77);
        wr(8'h0C, 32'h4000078);
        wr(8'h04, 32'h01);
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        chk({29'h0, tx_valid, tx_led, |port_ctrl}, 32'h0);
        rd(8'h08, q);
        chk(q, 32'h0);
        wrap_up;
    end
endmodule
`default_nettype wire
